// [rtl/switch_cycle_seq.sv]
// Flyback switch cycle sequencer: period, valley and catch timing, aux sampling,
// fault off period, APB registers and interrupt.
// Assumes comparator results arrive as clean inputs synchronous to pclk.
`include "switch_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module switch_cycle_seq #(
    parameter int MIN_CYC   = `MIN_PERIOD_CYC,
    parameter int CATCH_CYC = `CATCH_CYC,
    parameter int SMP_CYC   = `AUX_SAMPLE_CYC,
    parameter int FAULT_CYC = `FAULT_CYC
) (
    input  wire logic        pclk,               // System clock, 10 MHz
    input  wire logic        presetn,            // Async reset, active low
    input  wire logic        psel,               // APB select
    input  wire logic        penable,            // APB access phase
    input  wire logic        pwrite,             // APB write
    input  wire logic [11:0] paddr,              // APB byte address
    input  wire logic [31:0] pwdata,             // APB write data
    output logic      [31:0] prdata,             // APB read data
    output logic             pready,             // APB ready
    output logic             pslverr,            // APB error, unmapped address
    input  wire logic        valley_detect,      // Valley seen on aux winding
    input  wire logic        dimmer_filter_low,  // Dimmer filter input below 1 V
    input  wire logic        dimmer_filter_high, // Dimmer filter input above 1.2 V
    input  wire logic        aux_above_ovp,      // Aux above overvoltage threshold
    input  wire logic        vcc_ovp,            // Supply overvoltage comparator
    input  wire logic        comp_above_min,     // Compensation above minimum ramp
    input  wire logic        ramp_cross,         // Ramp crossed error amplifier
    output logic             main_switch,        // Gate drive
    output logic             comp_discharge,     // Discharge compensation node
    output logic             loop_enable,        // Control loop active
    output logic             irq                 // Interrupt, level
);

    // ======================================================================
    // Elaboration checks
    generate
        if (MIN_CYC < 2 || CATCH_CYC < 1 || SMP_CYC < 2 || FAULT_CYC < 2) begin : g_bad
            $error("switch_cycle_seq: timing counts too small");
        end
    endgenerate

    localparam int PW = $clog2(MIN_CYC + CATCH_CYC + 1);
    localparam int FW = $clog2(FAULT_CYC + 1);
    localparam int SW = $clog2(SMP_CYC + 1);
    localparam logic [PW-1:0] MIN_END   = PW'(MIN_CYC);
    localparam logic [PW-1:0] RAMP_LAST = PW'(MIN_CYC - 1);
    localparam logic [PW-1:0] CATCH_END = PW'(MIN_CYC + CATCH_CYC);
    localparam logic [FW-1:0] FAULT_END = FW'(FAULT_CYC - 1);
    localparam logic [SW-1:0] SMP_LOAD  = SW'(SMP_CYC);

    // ======================================================================
    // State
    switch_seq_pkg::seq_state_t state_r, state_nxt;
    logic [PW-1:0]           per_cnt_r;
    logic [FW-1:0]           fault_cnt_r;
    logic [SW-1:0]           smp_cnt_r;
    logic                    valley_en_r;
    logic [1:0]              ctrl_r;
    logic [`INT_WIDTH-1:0]   int_stat_r;
    logic [`INT_WIDTH-1:0]   int_mask_r;

    // ======================================================================
    // Cycle decode
    wire run_en     = ctrl_r[`CTRL_RUN_BIT];
    wire min_done   = per_cnt_r >= MIN_END;
    wire catch_done = per_cnt_r >= CATCH_END;
    wire valley_ok  = valley_en_r & ctrl_r[`CTRL_VALLEY_BIT] & valley_detect;
    wire turn_on    = min_done & (valley_ok | catch_done);
    wire on_end     = ramp_cross | (per_cnt_r == RAMP_LAST);
    wire sample_now = smp_cnt_r == SW'(1);
    wire aux_fault  = sample_now & aux_above_ovp;
    wire fault_go   = aux_fault | vcc_ovp;
    wire fault_done = fault_cnt_r == FAULT_END;
    wire restart    = (state_r == switch_seq_pkg::ST_FAULT) & fault_done & ~vcc_ovp;
    wire gate_fall  = main_switch & (state_nxt != switch_seq_pkg::ST_ON);

    // ======================================================================
    // Sequencer
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            switch_seq_pkg::ST_IDLE: begin
                if (fault_go) begin
                    state_nxt = switch_seq_pkg::ST_FAULT;
                end else if (run_en && comp_above_min) begin
                    state_nxt = switch_seq_pkg::ST_ON;
                end
            end
            switch_seq_pkg::ST_ON: begin
                if (fault_go) begin
                    state_nxt = switch_seq_pkg::ST_FAULT;
                end else if (!run_en) begin
                    state_nxt = switch_seq_pkg::ST_IDLE;
                end else if (on_end) begin
                    state_nxt = switch_seq_pkg::ST_OFF;
                end
            end
            switch_seq_pkg::ST_OFF: begin
                if (fault_go) begin
                    state_nxt = switch_seq_pkg::ST_FAULT;
                end else if (!run_en) begin
                    state_nxt = switch_seq_pkg::ST_IDLE;
                end else if (turn_on) begin
                    state_nxt = switch_seq_pkg::ST_ON;
                end
            end
            switch_seq_pkg::ST_FAULT: begin
                if (restart) begin
                    state_nxt = switch_seq_pkg::ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= switch_seq_pkg::ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Period counter restarts at each turn-on and saturates after catch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            per_cnt_r <= '0;
        end else if (state_nxt == switch_seq_pkg::ST_ON && state_r != switch_seq_pkg::ST_ON) begin
            per_cnt_r <= '0;
        end else if (!catch_done) begin
            per_cnt_r <= per_cnt_r + PW'(1);
        end
    end

    // Fault timer; a supply fault still present at the end rearms it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_cnt_r <= '0;
        end else if (state_r != switch_seq_pkg::ST_FAULT || fault_done) begin
            fault_cnt_r <= '0;
        end else begin
            fault_cnt_r <= fault_cnt_r + FW'(1);
        end
    end

    // Aux sample delay, loaded on each gate falling edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            smp_cnt_r <= '0;
        end else if (gate_fall) begin
            smp_cnt_r <= SMP_LOAD;
        end else if (smp_cnt_r != '0) begin
            smp_cnt_r <= smp_cnt_r - SW'(1);
        end
    end

    // Valley use with hysteresis between the two filter comparators
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            valley_en_r <= 1'b1;
        end else if (dimmer_filter_low) begin
            valley_en_r <= 1'b0;
        end else if (dimmer_filter_high) begin
            valley_en_r <= 1'b1;
        end
    end

    // Outputs follow the next state so each is a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            main_switch    <= 1'b0;
            comp_discharge <= 1'b1;
            loop_enable    <= 1'b0;
        end else begin
            main_switch    <= state_nxt == switch_seq_pkg::ST_ON;
            comp_discharge <= state_nxt == switch_seq_pkg::ST_FAULT;
            loop_enable    <= run_en && state_nxt != switch_seq_pkg::ST_FAULT;
        end
    end

    // ======================================================================
    // APB slave: no wait states, answer registered in setup
    wire setup    = psel & ~penable;
    wire wr_go    = psel & penable & pready & pwrite & ~pslverr;
    wire hit_ctrl = paddr == `CTRL_OFS;
    wire hit_stat = paddr == `STATUS_OFS;
    wire hit_ist  = paddr == `INT_STAT_OFS;
    wire hit_imsk = paddr == `INT_MASK_OFS;
    wire mapped   = hit_ctrl | hit_stat | hit_ist | hit_imsk;
    wire [31:0] rd_mux =
        hit_ctrl ? {30'h0, ctrl_r} :
        hit_stat ? {27'h0, valley_en_r, main_switch, comp_discharge, state_r} :
        hit_ist  ? {28'h0, int_stat_r} :
        hit_imsk ? {28'h0, int_mask_r} : 32'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h0;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~mapped;
            prdata  <= (setup & ~pwrite) ? rd_mux : 32'h0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= `CTRL_RESET;
            int_mask_r <= `INT_MASK_RESET;
        end else if (wr_go && hit_ctrl) begin
            ctrl_r     <= pwdata[1:0];
        end else if (wr_go && hit_imsk) begin
            int_mask_r <= pwdata[`INT_WIDTH-1:0];
        end
    end

    // ======================================================================
    // Interrupt: sticky events, a new event wins over a write-one clear
    wire [`INT_WIDTH-1:0] int_set = {restart,
                                     valley_en_r & dimmer_filter_low,
                                     vcc_ovp & state_r != switch_seq_pkg::ST_FAULT,
                                     aux_fault & state_r != switch_seq_pkg::ST_FAULT};
    wire [`INT_WIDTH-1:0] int_clr = (wr_go && hit_ist) ? pwdata[`INT_WIDTH-1:0] : '0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            int_stat_r <= '0;
            irq        <= 1'b0;
        end else begin
            int_stat_r <= (int_stat_r & ~int_clr) | int_set;
            irq        <= |(((int_stat_r & ~int_clr) | int_set) & int_mask_r);
        end
    end

    // ======================================================================
    // Assertions
    localparam int SMP_LAG = SMP_CYC - 1;

    min_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(main_switch) && $past(state_r) == switch_seq_pkg::ST_OFF
        |-> $past(per_cnt_r) >= MIN_END)
        else $error("gate on before minimum period");

    turn_on_cause_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(main_switch) && $past(state_r) == switch_seq_pkg::ST_OFF
        |-> $past(valley_ok) || $past(catch_done))
        else $error("gate on without valley or catch timeout");

    catch_turn_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == switch_seq_pkg::ST_OFF && per_cnt_r == CATCH_END && run_en && !fault_go
        |=> main_switch)
        else $error("catch timeout did not turn gate on");

    dimmer_no_valley_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(main_switch) && $past(state_r) == switch_seq_pkg::ST_OFF && !$past(valley_en_r)
        |-> $past(catch_done))
        else $error("valley used while dimmer present");

    hyst_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (dimmer_filter_low ##1 !dimmer_filter_high[*2]) |-> !valley_en_r)
        else $error("valley use returned without high level");

    aux_sample_a: assert property (@(posedge pclk) disable iff (!presetn)
        $fell(main_switch) |-> ##[SMP_LAG:SMP_LAG] sample_now)
        else $error("aux sample not at fixed delay");

    ovp_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        sample_now && aux_above_ovp |=> state_r == switch_seq_pkg::ST_FAULT && !main_switch)
        else $error("aux overvoltage not caught");

    fault_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == switch_seq_pkg::ST_FAULT && !fault_done
        |=> state_r == switch_seq_pkg::ST_FAULT && !main_switch)
        else $error("fault period cut short");

    fault_loop_a: assert property (@(posedge pclk) disable iff (!presetn)
        state_r == switch_seq_pkg::ST_FAULT |-> comp_discharge && !loop_enable)
        else $error("loop active during fault");

    restart_a: assert property (@(posedge pclk) disable iff (!presetn)
        restart |=> state_r == switch_seq_pkg::ST_IDLE && fault_cnt_r == '0)
        else $error("no restart after fault period");

    on_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        main_switch && ramp_cross |=> !main_switch)
        else $error("ramp crossing did not end on-time");

    comp_gate_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(main_switch) && $past(state_r) == switch_seq_pkg::ST_IDLE
        |-> $past(comp_above_min))
        else $error("gate on with low compensation");

    vcc_trip_a: assert property (@(posedge pclk) disable iff (!presetn)
        vcc_ovp |=> !main_switch ##1 !main_switch)
        else $error("supply overvoltage left gate on");

    ramp_end_a: assert property (@(posedge pclk) disable iff (!presetn)
        main_switch && per_cnt_r == RAMP_LAST |=> !main_switch)
        else $error("on-time past ramp period");

    valley_block_a: assert property (@(posedge pclk) disable iff (!presetn)
        !valley_en_r && state_r == switch_seq_pkg::ST_OFF && !catch_done |=> !main_switch)
        else $error("valley turn-on while dimmer present");

    run_off_a: assert property (@(posedge pclk) disable iff (!presetn)
        !run_en |=> !main_switch && !loop_enable)
        else $error("gate or loop active with run off");

    ready_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready |=> !pready)
        else $error("ready held past one cycle");

    // Scenarios
    valley_on_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == switch_seq_pkg::ST_OFF && valley_ok && min_done && !catch_done ##1 main_switch);
    catch_on_c: cover property (@(posedge pclk) disable iff (!presetn)
        state_r == switch_seq_pkg::ST_OFF && catch_done && !valley_ok ##1 main_switch);
    fault_c: cover property (@(posedge pclk) disable iff (!presetn) aux_fault ##1 comp_discharge);
    restart_c: cover property (@(posedge pclk) disable iff (!presetn) restart ##1 !comp_discharge);
    dimmer_c: cover property (@(posedge pclk) disable iff (!presetn)
        valley_en_r && dimmer_filter_low ##1 !valley_en_r);

endmodule

`default_nettype wire

// [rtl/switch_seq_defs.svh]
// Constants of the flyback switch cycle sequencer: offsets, fields, resets, times.
// Assumes a 100 ns system clock; cycle counts derive from the times below.
`ifndef SWITCH_SEQ_DEFS_SVH
`define SWITCH_SEQ_DEFS_SVH

// ==========================================================================
// Timing
`define CLK_PERIOD_NS     100
`define MIN_PERIOD_NS     14500
`define CATCH_TIMEOUT_NS  4000
`define AUX_SAMPLE_NS     1840
`define FAULT_OFF_MS      812
// Least times round up, longest times round down
`define MIN_PERIOD_CYC    ((`MIN_PERIOD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CATCH_CYC         (`CATCH_TIMEOUT_NS / `CLK_PERIOD_NS)
`define AUX_SAMPLE_CYC    ((`AUX_SAMPLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define FAULT_CYC         (`FAULT_OFF_MS * 1000000 / `CLK_PERIOD_NS)

// ==========================================================================
// Register offsets
`define CTRL_OFS          12'h000
`define STATUS_OFS        12'h004
`define INT_STAT_OFS      12'h008
`define INT_MASK_OFS      12'h00C

// ==========================================================================
// Fields and resets
`define CTRL_RUN_BIT      0
`define CTRL_VALLEY_BIT   1
`define CTRL_RESET        2'h3
`define INT_AUX_OVP_BIT   0
`define INT_VCC_OVP_BIT   1
`define INT_DIMMER_BIT    2
`define INT_RESTART_BIT   3
`define INT_WIDTH         4
`define INT_MASK_RESET    4'h0

`endif

// [rtl/switch_seq_pkg.sv]
// Types shared by the flyback switch cycle sequencer.
// Assumes nothing of its surroundings.
package switch_seq_pkg;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ON    = 2'b01,
        ST_OFF   = 2'b10,
        ST_FAULT = 2'b11
    } seq_state_t;

endpackage

// [sim/power_stage_model.sv]
// Behavioural flyback stage: ramp crossing, valley ringing, aux overshoot.
// Assumes a registered gate drive on pclk; knobs come from the bench.
`timescale 1ns/1ps
`default_nettype none
module power_stage_model (
    input  wire logic       pclk,          // System clock
    input  wire logic       presetn,       // Async reset, active low
    input  wire logic       main_switch,   // Gate drive
    input  wire logic       valley_on,     // Ring after turn-off
    input  wire logic       cross_on,      // Ramp reaches error level
    input  wire logic       aux_on,        // Aux winding overshoot
    input  wire logic [7:0] aux_dly,       // Overshoot start after turn-off
    output logic            valley_detect, // Valley now
    output logic            ramp_cross,    // Ramp above error level
    output logic            aux_above_ovp  // Aux above threshold
);
    logic [7:0] on_r;
    logic [7:0] off_r;
    // ==========================================
    // Phase counters, saturating so long faults never wrap
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            on_r  <= 8'h00;
            off_r <= 8'h00;
        end else begin
            on_r  <= main_switch ? on_r + {7'h0, on_r != 8'hFF} : 8'h00;
            off_r <= main_switch ? 8'h00 : off_r + {7'h0, off_r != 8'hFF};
        end
    end
    // Valleys come as short pulses, one per ring period; once off_r saturates at 8'hFF they become a level
    assign valley_detect = valley_on & ~main_switch & (off_r >= 8'h08) & (off_r[2:0] == 3'h7);
    assign ramp_cross    = cross_on & main_switch & (on_r >= 8'h1E);
    assign aux_above_ovp = aux_on & ~main_switch & (off_r >= aux_dly) & (off_r < aux_dly + 8'h05);
endmodule
`default_nettype wire

// [sim/flyback_switch_cycle_sequencer_tb.sv]
// Self-checking bench for the switch cycle sequencer.
// Assumes the power stage model beside it; fault period shortened to FC.
`include "switch_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none
module flyback_switch_cycle_sequencer_tb;
    localparam int FC = 50;
    localparam int CP = `MIN_PERIOD_CYC + `CATCH_CYC + 1;
    typedef struct packed {
        logic w; logic [11:0] a; logic [31:0] d; logic [31:0] rd; logic err;
    } row_t;
    row_t        rows [9];
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        valley_detect, dim_lo, dim_hi, aux_above_ovp, vcc_ovp, comp_ok;
    logic        ramp_cross, main_switch, comp_discharge, loop_enable, irq;
    logic        valley_on, cross_on, aux_on, bad;
    logic [7:0]  aux_dly;
    int          err_total, checked, cyc, on_t, per, n;

    switch_cycle_seq #(.FAULT_CYC(FC)) switch_cycle_seq_i (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .valley_detect(valley_detect),
        .dimmer_filter_low(dim_lo), .dimmer_filter_high(dim_hi),
        .aux_above_ovp(aux_above_ovp), .vcc_ovp(vcc_ovp), .comp_above_min(comp_ok),
        .ramp_cross(ramp_cross), .main_switch(main_switch),
        .comp_discharge(comp_discharge), .loop_enable(loop_enable), .irq(irq));
    power_stage_model power_stage_model_i (
        .pclk(pclk), .presetn(presetn), .main_switch(main_switch),
        .valley_on(valley_on), .cross_on(cross_on), .aux_on(aux_on),
        .aux_dly(aux_dly), .valley_detect(valley_detect),
        .ramp_cross(ramp_cross), .aux_above_ovp(aux_above_ovp));

    // ==========================================
    // Clock and hang guard
    initial begin
        pclk = 1'h0;
        forever #50 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            print_verdict();
        end
    end
    always @(negedge pclk) if (main_switch === 1'h1 && comp_ok === 1'h0) bad <= 1'h1;

    // ==========================================
    // Shared tasks
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'h1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do @(posedge pclk); while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
    endtask
    // On time and period of the next full gate cycle, in clocks
    task automatic meas();
        while (main_switch !== 1'h0) @(negedge pclk);
        while (main_switch !== 1'h1) @(negedge pclk);
        on_t = 0;
        do begin @(negedge pclk); on_t++; end while (main_switch === 1'h1);
        per = on_t;
        do begin @(negedge pclk); per++; end while (main_switch === 1'h0);
        // Return on a rising edge so callers drive inputs there
        @(posedge pclk);
    endtask
    task automatic wait_fault();
        while (comp_discharge !== 1'h1) @(negedge pclk);
    endtask
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // ==========================================
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata, vcc_ovp, comp_ok} = '0;
        {dim_lo, dim_hi, valley_on, cross_on, aux_on, aux_dly, bad} = {5'h08, 8'h00, 1'h0};
        rows[0] = '{1'h0, `CTRL_OFS, 32'h0, {30'h0, `CTRL_RESET}, 1'h0};
        rows[1] = '{1'h0, `INT_MASK_OFS, 32'h0, 32'h0, 1'h0};
        rows[2] = '{1'h0, `INT_STAT_OFS, 32'h0, 32'h0, 1'h0};
        rows[3] = '{1'h0, `STATUS_OFS, 32'h0, 32'h10, 1'h0};
        rows[4] = '{1'h1, `INT_MASK_OFS, 32'hFFFFFFFF, 32'h0, 1'h0};
        rows[5] = '{1'h0, `INT_MASK_OFS, 32'h0, 32'hF, 1'h0};
        rows[6] = '{1'h1, `INT_MASK_OFS, 32'h0, 32'h0, 1'h0};
        rows[7] = '{1'h0, 12'h010, 32'h0, 32'h0, 1'h1};
        rows[8] = '{1'h1, 12'h014, 32'h5, 32'h0, 1'h1};
        repeat (2) @(negedge pclk);
        chk("reset outputs", 32'h8, {27'h0, main_switch, comp_discharge, loop_enable, irq, pready});
        repeat (2) @(posedge pclk);
        presetn <= 1'h1;
        for (int i = 0; i < 9; i++) begin
            apb(rows[i].w, rows[i].a, rows[i].d);
            chk("slave error", {31'h0, rows[i].err}, {31'h0, er});
            if (!rows[i].w) chk("read data", rows[i].rd, rd);
        end
        chk("gate held low", 32'h0, {31'h0, bad});
        $display("register rows done");
        comp_ok <= 1'h1;
        meas();
        chk("on time limit", `MIN_PERIOD_CYC, on_t);
        chk("catch period", CP, per);
        chk("catch period", CP, per);
        chk("period end cuts on time", `MIN_PERIOD_CYC, on_t);
        valley_on <= 1'h1;
        repeat (2) meas();
        chk("valley period", 32'h1, {31'h0, per >= 146 && per < CP});
        $display("period tests done");
        dim_lo <= 1'h1;
        dim_hi <= 1'h0;
        repeat (2) meas();
        chk("dimmer period", CP, per);
        dim_lo <= 1'h0;
        repeat (2) meas();
        chk("hysteresis band", CP, per);
        dim_hi <= 1'h1;
        repeat (2) meas();
        chk("valley resumed", 32'h1, {31'h0, per < CP});
        apb(1'h0, `INT_STAT_OFS, 32'h0);
        chk("dimmer event", 32'h4, rd & 32'h4);
        apb(1'h1, `INT_STAT_OFS, 32'hF);
        cross_on <= 1'h1;
        repeat (2) meas();
        chk("ramp cross", 32'h1, {31'h0, on_t >= 30 && on_t <= 33});
        cross_on <= 1'h0;
        valley_on <= 1'h0;
        $display("dimmer and ramp tests done");
        aux_dly <= 8'h03;
        aux_on <= 1'h1;
        repeat (3) meas();
        apb(1'h0, `INT_STAT_OFS, 32'h0);
        chk("aux outside sample", 32'h0, rd);
        apb(1'h1, `INT_MASK_OFS, 32'h1);
        aux_dly <= 8'h10;
        wait_fault();
        @(posedge pclk);
        aux_on <= 1'h0;
        {n, bad} = '0;
        while (comp_discharge === 1'h1) begin
            if (main_switch !== 1'h0 || loop_enable !== 1'h0) bad = 1'h1;
            n++;
            @(negedge pclk);
        end
        chk("fault length", 32'h1, {31'h0, n >= FC - 2 && n <= FC + 2});
        chk("loop held off", 32'h0, {31'h0, bad});
        meas();
        chk("restart period", CP, per);
        chk("loop back on", 32'h1, {31'h0, loop_enable});
        apb(1'h0, `INT_STAT_OFS, 32'h0);
        chk("aux fault flag", 32'h9, rd & 32'h9);
        chk("irq raised", 32'h1, {31'h0, irq});
        apb(1'h1, `INT_STAT_OFS, 32'h1);
        repeat (3) @(negedge pclk);
        chk("irq masked", 32'h0, {31'h0, irq});
        apb(1'h0, `INT_STAT_OFS, 32'h0);
        chk("one bit cleared", 32'h8, rd & 32'h9);
        $display("aux fault tests done");
        apb(1'h1, `INT_MASK_OFS, 32'h2);
        vcc_ovp <= 1'h1;
        wait_fault();
        @(posedge pclk);
        vcc_ovp <= 1'h0;
        repeat (3) @(negedge pclk);
        chk("supply fault gate", 32'h1, {31'h0, irq & ~main_switch});
        meas();
        chk("supply fault over", CP, per);
        $display("supply fault test done");
        apb(1'h1, `CTRL_OFS, 32'h1);
        valley_on <= 1'h1;
        repeat (2) meas();
        chk("valley disallowed", CP, per);
        apb(1'h1, `CTRL_OFS, 32'h0);
        repeat (3) @(negedge pclk);
        chk("run off", 32'h0, {30'h0, main_switch, loop_enable});
        @(posedge pclk);
        presetn <= 1'h0;
        @(negedge pclk);
        chk("reset again", 32'h8, {27'h0, main_switch, comp_discharge, loop_enable, irq, pready});
        @(posedge pclk);
        presetn <= 1'h1;
        repeat (2) @(negedge pclk);
        chk("gate after reset", 32'h1, {31'h0, main_switch});
        $display("control and reset tests done");
        print_verdict();
    end
endmodule
`default_nettype wire
